// ===== bench/iag_checker.sv
// Purpose: Port-level checks on the aggregator.
// Assumes: clk_en is held high.
// Notes: Bound in below.
`default_nettype none
module iag_checker
   import iag_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [IAG_AW-1:0] paddr,
   input wire logic [IAG_DW-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [IAG_NLVL-1:0] level_src,
   input wire logic cpu_irq,
   input wire logic cpu_irq_high,
   input wire logic [IAG_IDW-1:0] cpu_irq_id
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_setup_gets_ready: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_in_access: assert property (pready |-> penable && $past(psel && !penable))
      else $error("pready outside access");
   a_read_byte_only: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_high_addr_err: assert property (pready && paddr[15:14] != 2'h0 |-> pslverr)
      else $error("no error on bad address");
   a_id_valid_source: assert property (cpu_irq |-> IAG_SRC_VALID[cpu_irq_id])
      else $error("request id not a source");
   a_idle_id_zero: assert property (!cpu_irq |-> cpu_irq_id == 5'h00 && !cpu_irq_high)
      else $error("id or high without request");
   a_level_id_held: assert property (cpu_irq && cpu_irq_id < 5'h10
      |-> (($past(level_src, 2) >> cpu_irq_id) & 16'h1) != 16'h0)
      else $error("level id without source");
   c_high: cover property (cpu_irq_high);
   c_edge: cover property (cpu_irq && cpu_irq_id >= 5'h10);
   c_err: cover property (pready && pslverr);
endmodule
bind iag_irq_aggregator iag_checker iag_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .level_src(level_src), .cpu_irq(cpu_irq),
   .cpu_irq_high(cpu_irq_high), .cpu_irq_id(cpu_irq_id));
`default_nettype wire

// ===== bench/iag_cpu_model.sv
// Purpose: CPU core taking requests.
// Assumes: Request is a level on pclk.
// Notes: No nesting of service routines.
`default_nettype none
module iag_cpu_model
   import iag_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cpu_irq,
   input wire logic [IAG_IDW-1:0] cpu_irq_id,
   output logic [IAG_IDW-1:0] taken_id,
   output logic in_service
);
   // Enters service only when idle and resumes once the request is gone.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {in_service, taken_id} <= '0;
      else if (cpu_irq && !in_service)
         {in_service, taken_id} <= {1'b1, cpu_irq_id};
      else if (!cpu_irq)
         in_service <= 1'b0;
endmodule
`default_nettype wire

// ===== bench/test_irq_aggregator_24src.sv
// Purpose: Self-checking bench for the aggregator.
// Assumes: Zero-wait APB; clk_en high.
// Notes: Byte address is four times the index.
`default_nettype none
module test_irq_aggregator_24src
   import iag_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [IAG_AW-1:0] paddr = '0;
   logic [IAG_DW-1:0] pwdata = '0;
   logic [IAG_DW-1:0] prdata, rd;
   logic pready, pslverr, cpu_irq, cpu_irq_high, stat_irq, in_service;
   logic [IAG_NLVL-1:0] level_src = '0;
   logic [IAG_NEDGE-1:0] edge_src = '0;
   logic [IAG_IDW-1:0] cpu_irq_id, taken_id;
   int fails = 0, n_compared = 0, cycles = 0;
   always #50 pclk = ~pclk;
   iag_irq_aggregator iag_irq_aggregator_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .level_src(level_src), .edge_src(edge_src), .cpu_irq(cpu_irq),
      .cpu_irq_high(cpu_irq_high), .cpu_irq_id(cpu_irq_id), .stat_irq(stat_irq));
   iag_cpu_model iag_cpu_model_i (.pclk(pclk), .presetn(presetn), .cpu_irq(cpu_irq),
      .cpu_irq_id(cpu_irq_id), .taken_id(taken_id), .in_service(in_service));
   task automatic final_report();
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready wait cycles", 32'd1, 32'(n));
   endtask
   task automatic rchk(input logic [11:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), {24'h0, e}, rd);
   endtask
   task automatic irq(input logic e, input logic [4:0] id, input logic hi);
      chk("cpu_irq", {31'h0, e}, {31'h0, cpu_irq});
      chk("cpu_irq_id", {27'h0, id}, {27'h0, cpu_irq_id});
      chk("cpu_irq_high", {31'h0, hi}, {31'h0, cpu_irq_high});
   endtask
   task automatic t_regs();
      logic [7:0] exp [7] = '{8'hff, 8'h7f, 8'h7f, 8'h01, 8'hff, 8'h7f, 8'h7f};
      for (int i = 0; i < 14; i++)
         if (i != 7 && i != 11)
            rchk(IAG_IDX_EN0 + 12'(i), 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, IAG_IDX_EN0 + 12'(i), 8'hff);
         rchk(IAG_IDX_EN0 + 12'(i), exp[i]);
      end
      apb(1'b1, IAG_IDX_PEND0, 8'hff);
      rchk(IAG_IDX_PEND0, 8'h00);
      apb(1'b0, 12'h647, 8'h00);
      chk("pslverr", 32'h1, {31'h0, err});
   endtask
   task automatic t_level();
      for (int i = 0; i < 3; i++)
         apb(1'b1, IAG_IDX_PRIO0 + 12'(i), 8'h00);
      level_src <= 16'h0008;
      tick(3);
      irq(1'b1, 5'd3, 1'b0);
      rchk(IAG_IDX_PEND0, 8'h08);
      chk("taken_id", 32'd3, {27'h0, taken_id});
      level_src <= 16'h0201;
      tick(3);
      irq(1'b1, 5'd0, 1'b0);
      apb(1'b1, IAG_IDX_PRIO1, 8'h02);
      tick(2);
      irq(1'b1, 5'd9, 1'b1);
      apb(1'b1, IAG_IDX_CTRL, 8'h00);
      tick(2);
      irq(1'b0, 5'd0, 1'b0);
      apb(1'b1, IAG_IDX_CTRL, 8'h01);
      level_src <= 16'h0000;
      tick(3);
      irq(1'b0, 5'd0, 1'b0);
      rchk(IAG_IDX_PEND1, 8'h00);
   endtask
   task automatic t_edge();
      apb(1'b1, IAG_IDX_SMASK, 8'h01);
      edge_src <= 8'h04;
      tick(1);
      edge_src <= 8'h00;
      tick(3);
      irq(1'b1, 5'd18, 1'b0);
      chk("stat_irq", 32'h1, {31'h0, stat_irq});
      rchk(IAG_IDX_STAT, 8'h03);
      rchk(IAG_IDX_PEND2, 8'h04);
      apb(1'b1, IAG_IDX_PEND2, 8'h04);
      rchk(IAG_IDX_PEND2, 8'h00);
      irq(1'b0, 5'd0, 1'b0);
      apb(1'b1, IAG_IDX_STAT, 8'h03);
      tick(2);
      chk("stat_irq", 32'h0, {31'h0, stat_irq});
   endtask
   initial
   begin
      tick(2);
      presetn <= 1'b1;
      t_regs();
      t_level();
      t_edge();
      final_report();
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         final_report();
      end
   end
endmodule
`default_nettype wire

// ===== src/iag_irq_aggregator.sv
// Purpose: Gathers 24 peripheral interrupt sources into one prioritised CPU request.
// Assumes: Sources come from logic on pclk; APB master follows the usual protocol.
// Notes: Zero-wait APB slave; unmapped addresses answer with pslverr.
`default_nettype none
module iag_irq_aggregator
   import iag_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [IAG_AW-1:0] paddr,
   input wire logic [IAG_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [IAG_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [IAG_NLVL-1:0] level_src,
   input wire logic [IAG_NEDGE-1:0] edge_src,
   output logic cpu_irq,
   output logic cpu_irq_high,
   output logic [IAG_IDW-1:0] cpu_irq_id,
   output logic stat_irq
);

   // Address decoding shared by the read and write paths.
   function automatic iag_reg_t decode(input logic [IAG_AW-1:0] a);
      iag_reg_t r;
      r = IAG_R_NONE;
      if (a[1:0] != 2'h0 || a[IAG_AW-1:14] != 2'h0)
      begin
         r = IAG_R_NONE;
      end
      else if (a[13:2] == IAG_IDX_EN0)
      begin
         r = IAG_R_EN0;
      end
      else if (a[13:2] == IAG_IDX_EN1)
      begin
         r = IAG_R_EN1;
      end
      else if (a[13:2] == IAG_IDX_EN2)
      begin
         r = IAG_R_EN2;
      end
      else if (a[13:2] == IAG_IDX_CTRL)
      begin
         r = IAG_R_CTRL;
      end
      else if (a[13:2] == IAG_IDX_PRIO0)
      begin
         r = IAG_R_PRIO0;
      end
      else if (a[13:2] == IAG_IDX_PRIO1)
      begin
         r = IAG_R_PRIO1;
      end
      else if (a[13:2] == IAG_IDX_PRIO2)
      begin
         r = IAG_R_PRIO2;
      end
      else if (a[13:2] == IAG_IDX_PEND0)
      begin
         r = IAG_R_PEND0;
      end
      else if (a[13:2] == IAG_IDX_PEND1)
      begin
         r = IAG_R_PEND1;
      end
      else if (a[13:2] == IAG_IDX_PEND2)
      begin
         r = IAG_R_PEND2;
      end
      else if (a[13:2] == IAG_IDX_STAT)
      begin
         r = IAG_R_STAT;
      end
      else if (a[13:2] == IAG_IDX_SMASK)
      begin
         r = IAG_R_SMASK;
      end
      return r;
   endfunction

   // Lowest-numbered set bit; used for both priority levels.
   function automatic logic [IAG_IDW-1:0] first_set(input logic [IAG_NSRC-1:0] v);
      logic [IAG_IDW-1:0] id;
      id = '0;
      for (int i = IAG_NSRC - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            id = IAG_IDW'(i);
         end
      end
      return id;
   endfunction

   logic [IAG_NSRC-1:0] en_q, en_d;
   logic [IAG_NSRC-1:0] prio_q, prio_d;
   logic ctrl_en_q, ctrl_en_d;
   logic [IAG_NLVL-1:0] lvl_q, lvl_d;
   logic [IAG_NEDGE-1:0] edge_flag_q, edge_flag_d;
   logic [IAG_NEDGE-1:0] edge_prev_q, edge_prev_d;
   logic [1:0] stat_q, stat_d;
   logic [1:0] smask_q, smask_d;
   logic [IAG_DW-1:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic req_q, req_d;
   logic high_q, high_d;
   logic [IAG_IDW-1:0] id_q, id_d;
   logic stat_irq_q, stat_irq_d;

   logic setup_ph, wr_acc;
   iag_reg_t rsel, wsel;
   logic [7:0] wbyte;
   logic [IAG_NSRC-1:0] pend, act, act_hi;
   logic [IAG_NEDGE-1:0] edge_rise, edge_clr;

   assign setup_ph = psel && !penable;
   // Writes take effect only at the access edge where pready is seen high.
   assign wr_acc = psel && penable && pready_q && pwrite && pstrb[0];
   assign rsel = decode(paddr);
   assign wsel = rsel;
   assign wbyte = pwdata[7:0];
   assign pend = {edge_flag_q, lvl_q};
   assign act = pend & en_q;
   assign act_hi = act & prio_q;
   assign edge_rise = edge_src & ~edge_prev_q & IAG_EDGE_VALID;
   assign edge_clr = (wr_acc && wsel == IAG_R_PEND2) ? wbyte : 8'h00;

   always_comb
   begin
      en_d = en_q;
      prio_d = prio_q;
      ctrl_en_d = ctrl_en_q;
      smask_d = smask_q;
      if (wr_acc)
      begin
         case (wsel)
            IAG_R_EN0: en_d[7:0] = wbyte;
            IAG_R_EN1: en_d[15:8] = wbyte & IAG_SRC_VALID[15:8];
            IAG_R_EN2: en_d[23:16] = wbyte & IAG_SRC_VALID[23:16];
            IAG_R_CTRL: ctrl_en_d = wbyte[IAG_CTRL_EN_BIT];
            IAG_R_PRIO0: prio_d[7:0] = wbyte;
            IAG_R_PRIO1: prio_d[15:8] = wbyte & IAG_SRC_VALID[15:8];
            IAG_R_PRIO2: prio_d[23:16] = wbyte & IAG_SRC_VALID[23:16];
            IAG_R_SMASK: smask_d = wbyte[1:0] & IAG_STAT_VALID;
            default: ;
         endcase
      end
   end

   always_comb
   begin
      // Level flags mirror the peripheral; no register write can clear them.
      lvl_d = level_src & IAG_LVL_VALID;
      edge_prev_d = edge_src;
      // A new edge in the clearing cycle wins, so no event is lost.
      edge_flag_d = (edge_flag_q & ~edge_clr) | edge_rise;
      stat_d = stat_q;
      if (wr_acc && wsel == IAG_R_STAT)
      begin
         stat_d = stat_q & ~wbyte[1:0];
      end
      if (|edge_rise)
      begin
         stat_d[IAG_STAT_EDGE_BIT] = 1'b1;
      end
      if (req_d && !req_q)
      begin
         stat_d[IAG_STAT_REQ_BIT] = 1'b1;
      end
      stat_irq_d = |(stat_d & smask_d);
   end

   always_comb
   begin
      // The request is a level held until the CPU's handler removes the cause.
      req_d = ctrl_en_q && (|act);
      high_d = req_d && (|act_hi);
      // With no request the index reads zero, so a stale id is never mistaken for a live one.
      id_d = '0;
      if (req_d)
      begin
         id_d = (|act_hi) ? first_set(act_hi) : first_set(act);
      end
   end

   always_comb
   begin
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      pready_d = setup_ph;
      if (setup_ph)
      begin
         prdata_d = '0;
         pslverr_d = (rsel == IAG_R_NONE);
         if (!pwrite)
         begin
            case (rsel)
               IAG_R_EN0: prdata_d[7:0] = en_q[7:0];
               IAG_R_EN1: prdata_d[7:0] = en_q[15:8];
               IAG_R_EN2: prdata_d[7:0] = en_q[23:16];
               IAG_R_CTRL: prdata_d[IAG_CTRL_EN_BIT] = ctrl_en_q;
               IAG_R_PRIO0: prdata_d[7:0] = prio_q[7:0];
               IAG_R_PRIO1: prdata_d[7:0] = prio_q[15:8];
               IAG_R_PRIO2: prdata_d[7:0] = prio_q[23:16];
               IAG_R_PEND0: prdata_d[7:0] = pend[7:0];
               IAG_R_PEND1: prdata_d[7:0] = pend[15:8];
               IAG_R_PEND2: prdata_d[7:0] = pend[23:16];
               IAG_R_STAT: prdata_d[1:0] = stat_q;
               IAG_R_SMASK: prdata_d[1:0] = smask_q;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_q <= IAG_RST_WORD;
         prio_q <= IAG_RST_WORD;
         ctrl_en_q <= 1'b0;
         smask_q <= IAG_RST_STAT;
      end
      else if (clk_en)
      begin
         en_q <= en_d;
         prio_q <= prio_d;
         ctrl_en_q <= ctrl_en_d;
         smask_q <= smask_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvl_q <= IAG_RST_WORD[15:0];
         edge_flag_q <= IAG_RST_BYTE;
         edge_prev_q <= IAG_RST_BYTE;
         stat_q <= IAG_RST_STAT;
         stat_irq_q <= 1'b0;
      end
      else if (clk_en)
      begin
         lvl_q <= lvl_d;
         edge_flag_q <= edge_flag_d;
         edge_prev_q <= edge_prev_d;
         stat_q <= stat_d;
         stat_irq_q <= stat_irq_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_q <= 1'b0;
         high_q <= 1'b0;
         id_q <= '0;
      end
      else if (clk_en)
      begin
         req_q <= req_d;
         high_q <= high_d;
         id_q <= id_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else if (clk_en)
      begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cpu_irq = req_q;
   assign cpu_irq_high = high_q;
   assign cpu_irq_id = id_q;
   assign stat_irq = stat_irq_q;

endmodule
`default_nettype wire

// ===== src/iag_pkg.sv
// Purpose: Shared constants for the 24-source interrupt aggregator.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes: Register indices are word offsets; the bus address is four times the index.
`default_nettype none
package iag_pkg;
   localparam int unsigned IAG_AW = 16;
   localparam int unsigned IAG_DW = 32;
   localparam int unsigned IAG_NSRC = 24;
   localparam int unsigned IAG_NLVL = 16;
   localparam int unsigned IAG_NEDGE = 8;
   localparam int unsigned IAG_IDW = 5;

   // Register indices; bus byte address is the index times four.
   localparam logic [11:0] IAG_IDX_EN0 = 12'h640;
   localparam logic [11:0] IAG_IDX_EN1 = 12'h641;
   localparam logic [11:0] IAG_IDX_EN2 = 12'h642;
   localparam logic [11:0] IAG_IDX_CTRL = 12'h643;
   localparam logic [11:0] IAG_IDX_PRIO0 = 12'h644;
   localparam logic [11:0] IAG_IDX_PRIO1 = 12'h645;
   localparam logic [11:0] IAG_IDX_PRIO2 = 12'h646;
   localparam logic [11:0] IAG_IDX_PEND0 = 12'h648;
   localparam logic [11:0] IAG_IDX_PEND1 = 12'h649;
   localparam logic [11:0] IAG_IDX_PEND2 = 12'h64a;
   localparam logic [11:0] IAG_IDX_STAT = 12'h64c;
   localparam logic [11:0] IAG_IDX_SMASK = 12'h64d;

   // Reset values.
   localparam logic [7:0] IAG_RST_BYTE = 8'h00;
   localparam logic [23:0] IAG_RST_WORD = 24'h000000;
   localparam logic [1:0] IAG_RST_STAT = 2'h0;

   // Field positions and implemented-bit masks.
   localparam int unsigned IAG_CTRL_EN_BIT = 0;
   localparam logic [23:0] IAG_SRC_VALID = 24'h7f7fff;
   localparam logic [15:0] IAG_LVL_VALID = 16'h7fff;
   localparam logic [7:0] IAG_EDGE_VALID = 8'h7f;
   localparam int unsigned IAG_STAT_EDGE_BIT = 0;
   localparam int unsigned IAG_STAT_REQ_BIT = 1;
   localparam logic [1:0] IAG_STAT_VALID = 2'h3;

   typedef enum logic [3:0] {
      IAG_R_EN0, IAG_R_EN1, IAG_R_EN2, IAG_R_CTRL,
      IAG_R_PRIO0, IAG_R_PRIO1, IAG_R_PRIO2,
      IAG_R_PEND0, IAG_R_PEND1, IAG_R_PEND2,
      IAG_R_STAT, IAG_R_SMASK, IAG_R_NONE
   } iag_reg_t;
endpackage
`default_nettype wire
